// file: design/bso_shifter_top.sv
// Operand-two barrel shifter, data-processing ALU and flag write-back
`timescale 1ns/1ps

module bso_shifter_top
    import bso_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // AXI4-Lite write address and data
    input wire logic [BSO_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read
    input wire logic [BSO_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // Reset synchroniser
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Software-visible state
    logic [31:0] instr;
    logic [31:0] first_operand_reg;
    logic [31:0] shift_source_reg;
    logic [31:0] shift_amount_reg;
    logic [31:0] instr_addr;
    logic [31:0] status_word;
    logic [31:0] saved_status_word;
    logic [31:0] result;
    logic [31:0] program_counter_reg;
    logic [31:0] info;
    logic go;

    // Bus channel state
    logic aw_held;
    logic w_held;
    logic [BSO_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Instruction decode
    wire logic imm_form = instr[IN_IMM];
    wire logic [3:0] opcode = instr[IN_OPC_LO +: 4];
    wire logic set_flags = instr[IN_SETF];
    wire logic [3:0] first_idx = instr[IN_FIRST_LO +: 4];
    wire logic [3:0] dest_idx = instr[IN_DEST_LO +: 4];
    wire logic [3:0] src_idx = instr[IN_SRC_LO +: 4];
    wire logic [3:0] amt_idx = instr[IN_AMTREG_LO +: 4];
    wire logic reg_shift = !imm_form && instr[IN_REGSH];
    wire logic undef_op = reg_shift && instr[IN_BIT7];
    wire logic bad_amt = reg_shift && (amt_idx == PC_IDX);
    wire bso_shift_t shift_kind = bso_shift_t'(instr[IN_STYPE_LO +: 2]);
    wire logic carry_in = status_word[ST_C];
    wire logic user_mode = (status_word[4:0] == MODE_USER);
    wire logic is_test = (opcode[3:2] == 2'b10);
    wire logic dest_pc = (dest_idx == PC_IDX);
    wire logic pc_written = dest_pc && !is_test;

    // Program counter seen as an operand
    wire logic [31:0] pc_ahead =
        instr_addr + (reg_shift ? PC_AHEAD_REG : PC_AHEAD_IMM);
    wire logic [31:0] op_first =
        (first_idx == PC_IDX) ? pc_ahead : first_operand_reg;
    wire logic [31:0] op_src =
        (src_idx == PC_IDX) ? pc_ahead : shift_source_reg;

    // Amount: low byte of the register, or the 5-bit field
    wire logic [7:0] shift_amt = reg_shift ? shift_amount_reg[7:0]
                                           : {3'b000, instr[IN_SHAMT_LO +: 5]};

    // Barrel shifter for a register operand
    function automatic bso_shout_t shift_unit(
        input logic [31:0] src,
        input bso_shift_t kind,
        input logic [7:0] amt,
        input logic by_reg,
        input logic cin
    );
        logic [32:0] wide;
        logic [63:0] dbl;
        logic [7:0] eff;
        bso_shout_t r;
        wide = '0;
        dbl = '0;
        r.value = src;
        r.carry = cin;
        // For logical and arithmetic right shifts a zero immediate field encodes a full 32-bit shift
        eff = (!by_reg && amt == 8'h00) ? SHIFT_FULL : amt;
        unique case (kind)
            SH_LOGICAL_LEFT:
            begin
                if (amt != 8'h00 && amt < SHIFT_FULL)
                begin
                    wide = {1'b0, src} << amt[4:0];
                    r.value = wide[31:0];
                    r.carry = wide[32];
                end
                else if (amt == SHIFT_FULL)
                begin
                    r.value = '0;
                    r.carry = src[0];
                end
                else if (amt != 8'h00)
                begin
                    r.value = '0;
                    r.carry = 1'b0;
                end
            end
            SH_LOGICAL_RIGHT:
            begin
                if (eff != 8'h00 && eff < SHIFT_FULL)
                begin
                    wide = {src, 1'b0} >> eff[4:0];
                    r.value = wide[32:1];
                    r.carry = wide[0];
                end
                else if (eff == SHIFT_FULL)
                begin
                    r.value = '0;
                    r.carry = src[31];
                end
                else if (eff != 8'h00)
                begin
                    r.value = '0;
                    r.carry = 1'b0;
                end
            end
            SH_ARITH_RIGHT:
            begin
                if (eff != 8'h00 && eff < SHIFT_FULL)
                begin
                    wide = 33'($signed({src, 1'b0}) >>> eff[4:0]);
                    r.value = wide[32:1];
                    r.carry = wide[0];
                end
                else if (eff != 8'h00)
                begin
                    r.value = {32{src[31]}};
                    r.carry = src[31];
                end
            end
            SH_ROTATE_RIGHT:
            begin
                if (!by_reg && amt == 8'h00)
                begin
                    r.value = {cin, src[31:1]};
                    r.carry = src[0];
                end
                else if (amt != 8'h00)
                begin
                    // Low five bits reduce any amount into 0..31
                    dbl = {src, src} >> amt[4:0];
                    r.value = dbl[31:0];
                    r.carry = dbl[31];
                end
            end
        endcase
        return r;
    endfunction

    // Rotated immediate operand
    wire logic [4:0] rot_amt = {instr[IN_ROT_LO +: 4], 1'b0};
    wire logic [63:0] imm_dbl = {24'h000000, instr[7:0],
                                 24'h000000, instr[7:0]} >> rot_amt;
    wire bso_shout_t imm_out = '{value: imm_dbl[31:0],
        carry: (rot_amt == 5'h00) ? carry_in : imm_dbl[31]};
    wire bso_shout_t reg_out =
        shift_unit(op_src, shift_kind, shift_amt, reg_shift, carry_in);
    wire bso_shout_t operand2 = imm_form ? imm_out : reg_out;

    // ALU
    logic [31:0] add_x;
    logic [31:0] add_y;
    logic add_c;
    logic [32:0] sum;
    logic [31:0] alu_res;
    logic arith;

    always_comb
    begin
        add_x = op_first;
        add_y = operand2.value;
        add_c = 1'b0;
        arith = 1'b1;
        unique case (opcode)
            OP_SUB, OP_CMP:
            begin
                add_y = ~operand2.value;
                add_c = 1'b1;
            end
            OP_RSB:
            begin
                add_x = operand2.value;
                add_y = ~op_first;
                add_c = 1'b1;
            end
            OP_ADD, OP_CMN: add_c = 1'b0;
            OP_ADC: add_c = carry_in;
            OP_SBC:
            begin
                add_y = ~operand2.value;
                add_c = carry_in;
            end
            OP_RSC:
            begin
                add_x = operand2.value;
                add_y = ~op_first;
                add_c = carry_in;
            end
            default: arith = 1'b0;
        endcase
        sum = {1'b0, add_x} + {1'b0, add_y} + {32'h0, add_c};
        unique case (opcode)
            OP_AND, OP_TSTB: alu_res = op_first & operand2.value;
            OP_EOR, OP_TEQV: alu_res = op_first ^ operand2.value;
            OP_ORR: alu_res = op_first | operand2.value;
            OP_MOV: alu_res = operand2.value;
            OP_BIC: alu_res = op_first & ~operand2.value;
            OP_MVN: alu_res = ~operand2.value;
            default: alu_res = sum[31:0];
        endcase
    end

    wire logic ovf = (add_x[31] == add_y[31]) && (sum[31] != add_x[31]);
    wire logic [3:0] flags_new = arith
        ? {alu_res[31], alu_res == 32'h0, sum[32], ovf}
        : {alu_res[31], alu_res == 32'h0, operand2.carry,
           status_word[ST_V]};
    wire logic restore = dest_pc && set_flags && !user_mode;
    wire logic upd_flags = set_flags && !dest_pc;
    wire logic suppress = undef_op || bad_amt;

    // Incremental cost per instruction class
    wire bso_cost_t cost = '{
        s_cyc: pc_written ? 4'h2 : 4'h1,
        n_cyc: pc_written ? 4'h1 : 4'h0,
        i_cyc: reg_shift ? 4'h1 : 4'h0};

    // Bus decode
    wire logic aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire logic w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire logic wr_fire = aw_held && w_held && !S_AXI_BVALID;
    wire logic [7:0] wr_ofs = {aw_addr[7:2], 2'b00};
    wire logic [7:0] rd_ofs = {S_AXI_ARADDR[7:2], 2'b00};
    wire logic [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                               {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire logic wr_ok = (wr_ofs <= OFS_SAVED);
    wire logic rd_ok = (rd_ofs <= OFS_INFO);
    logic [31:0] rd_mux;

    always_comb
    begin
        unique case (rd_ofs)
            OFS_CTRL: rd_mux = 32'h0;
            OFS_INSTR: rd_mux = instr;
            OFS_FIRST: rd_mux = first_operand_reg;
            OFS_SRC: rd_mux = shift_source_reg;
            OFS_AMT: rd_mux = shift_amount_reg;
            OFS_IADDR: rd_mux = instr_addr;
            OFS_STATUS: rd_mux = status_word;
            OFS_SAVED: rd_mux = saved_status_word;
            OFS_RESULT: rd_mux = result;
            OFS_PCOUT: rd_mux = program_counter_reg;
            OFS_INFO: rd_mux = info;
            default: rd_mux = 32'h0;
        endcase
    end

    // Write-side handshakes
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end
        else
        begin
            if (aw_take)
            begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (w_take)
            begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // Read side
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_mux;
            S_AXI_RRESP <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // Operand registers, software writes only
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            instr <= '0;
            first_operand_reg <= '0;
            shift_source_reg <= '0;
            shift_amount_reg <= '0;
            instr_addr <= '0;
            go <= 1'b0;
        end
        else
        begin
            go <= wr_fire && wr_ofs == OFS_CTRL && w_strb[0] && w_data[CTRL_GO];
            if (wr_fire)
            begin
                unique case (wr_ofs)
                    OFS_INSTR:
                        instr <= (instr & ~wmask) | (w_data & wmask);
                    OFS_FIRST: first_operand_reg <=
                        (first_operand_reg & ~wmask) | (w_data & wmask);
                    OFS_SRC: shift_source_reg <=
                        (shift_source_reg & ~wmask) | (w_data & wmask);
                    OFS_AMT: shift_amount_reg <=
                        (shift_amount_reg & ~wmask) | (w_data & wmask);
                    OFS_IADDR:
                        instr_addr <= (instr_addr & ~wmask) | (w_data & wmask);
                    default: ;
                endcase
            end
        end
    end

    // Execution and status write-back; go never meets a bus write
    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_word <= STATUS_RST;
            saved_status_word <= SAVED_RST;
            result <= '0;
            program_counter_reg <= '0;
            info <= '0;
        end
        else if (go)
        begin
            info <= {12'h0, cost.i_cyc, cost.n_cyc, cost.s_cyc, 3'b000,
                     !suppress && !is_test, bad_amt, undef_op,
                     !suppress && pc_written, 1'b1};
            if (!suppress && !is_test)
                result <= alu_res;
            if (!suppress && pc_written)
                program_counter_reg <= alu_res;
            if (!suppress && restore)
                status_word <= saved_status_word;
            else if (!suppress && upd_flags)
                status_word[ST_N:ST_V] <= flags_new;
        end
        else if (wr_fire && wr_ofs == OFS_STATUS)
            status_word <= (status_word & ~wmask) | (w_data & wmask);
        else if (wr_fire && wr_ofs == OFS_SAVED)
            saved_status_word <=
                (saved_status_word & ~wmask) | (w_data & wmask);
    end
endmodule

// file: design/bso_pkg.sv
// Constants, field layouts and types for the operand-two shifter block
package bso_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam int unsigned BSO_ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_INSTR = 8'h04;
    localparam logic [7:0] OFS_FIRST = 8'h08;
    localparam logic [7:0] OFS_SRC = 8'h0C;
    localparam logic [7:0] OFS_AMT = 8'h10;
    localparam logic [7:0] OFS_IADDR = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_SAVED = 8'h1C;
    localparam logic [7:0] OFS_RESULT = 8'h20;
    localparam logic [7:0] OFS_PCOUT = 8'h24;
    localparam logic [7:0] OFS_INFO = 8'h28;

    // Control register
    localparam int unsigned CTRL_GO = 0;

    // Instruction word fields
    localparam int unsigned IN_IMM = 25;
    localparam int unsigned IN_OPC_LO = 21;
    localparam int unsigned IN_SETF = 20;
    localparam int unsigned IN_FIRST_LO = 16;
    localparam int unsigned IN_DEST_LO = 12;
    localparam int unsigned IN_ROT_LO = 8;
    localparam int unsigned IN_AMTREG_LO = 8;
    localparam int unsigned IN_SHAMT_LO = 7;
    localparam int unsigned IN_BIT7 = 7;
    localparam int unsigned IN_STYPE_LO = 5;
    localparam int unsigned IN_REGSH = 4;
    localparam int unsigned IN_SRC_LO = 0;

    // Status word fields
    localparam int unsigned ST_N = 31;
    localparam int unsigned ST_Z = 30;
    localparam int unsigned ST_C = 29;
    localparam int unsigned ST_V = 28;
    localparam logic [4:0] MODE_USER = 5'h10;
    localparam logic [31:0] STATUS_RST = 32'h0000_0013;
    localparam logic [31:0] SAVED_RST = 32'h0000_0000;

    // Info register fields
    localparam int unsigned INF_DONE = 0;
    localparam int unsigned INF_PCW = 1;
    localparam int unsigned INF_UNDEF = 2;
    localparam int unsigned INF_BADAMT = 3;
    localparam int unsigned INF_RESW = 4;
    localparam int unsigned INF_SCYC_LO = 8;
    localparam int unsigned INF_NCYC_LO = 12;
    localparam int unsigned INF_ICYC_LO = 16;

    // Program counter as an operand, and the full 32-bit shift amount
    localparam logic [3:0] PC_IDX = 4'hF;
    localparam logic [31:0] PC_AHEAD_IMM = 32'h0000_0008;
    localparam logic [31:0] PC_AHEAD_REG = 32'h0000_000C;
    localparam logic [7:0] SHIFT_FULL = 8'h20;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Opcodes
    localparam logic [3:0] OP_AND = 4'h0;
    localparam logic [3:0] OP_EOR = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_RSB = 4'h3;
    localparam logic [3:0] OP_ADD = 4'h4;
    localparam logic [3:0] OP_ADC = 4'h5;
    localparam logic [3:0] OP_SBC = 4'h6;
    localparam logic [3:0] OP_RSC = 4'h7;
    localparam logic [3:0] OP_TSTB = 4'h8;
    localparam logic [3:0] OP_TEQV = 4'h9;
    localparam logic [3:0] OP_CMP = 4'hA;
    localparam logic [3:0] OP_CMN = 4'hB;
    localparam logic [3:0] OP_ORR = 4'hC;
    localparam logic [3:0] OP_MOV = 4'hD;
    localparam logic [3:0] OP_BIC = 4'hE;
    localparam logic [3:0] OP_MVN = 4'hF;

    typedef enum logic [1:0] {
        SH_LOGICAL_LEFT,
        SH_LOGICAL_RIGHT,
        SH_ARITH_RIGHT,
        SH_ROTATE_RIGHT
    } bso_shift_t;

    typedef struct packed {
        logic [31:0] value;
        logic carry;
    } bso_shout_t;

    typedef struct packed {
        logic [3:0] s_cyc;
        logic [3:0] n_cyc;
        logic [3:0] i_cyc;
    } bso_cost_t;
endpackage

// file: test/bso_shifter_asserts.sv
// Bus handshake assertions for the operand-two shifter block
`timescale 1ns/1ps
module bso_shifter_asserts
    import bso_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Write side
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // Read side
    input wire logic [BSO_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    wire logic w_both = S_AXI_AWVALID && S_AXI_AWREADY
        && S_AXI_WVALID && S_AXI_WREADY;
    wire logic ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
    property p_b_hold;
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
    property p_r_hold;
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
    property p_b_time;
        w_both |-> ##[1:2] S_AXI_BVALID;
    endproperty
    a_b_time: assert property (p_b_time) else $error("bvalid late");
    property p_r_time;
        ar_hs |=> S_AXI_RVALID;
    endproperty
    a_r_time: assert property (p_r_time) else $error("rvalid late");
    property p_w_busy;
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
    endproperty
    a_w_busy: assert property (p_w_busy) else $error("write ready early");
    property p_b_done;
        S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write not closed");
    property p_r_done;
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read not closed");
    property p_unmapped;
        ar_hs && S_AXI_ARADDR[7:2] > 6'h0A
            |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("bad unmapped read");
    c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
    c_err: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
endmodule

bind bso_shifter_top bso_shifter_asserts u_chk (.CLK, .RESET_N,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY);

// file: test/bso_shifter_top_tb.sv
// Self-checking bench for the operand-two shifter block
`timescale 1ns/1ps
module bso_shifter_top_tb;
    import bso_pkg::*;
    logic clk = '0;
    logic rst_n = '0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [33:0] q[$];
    int mismatches = 0, samples_checked = 0;
    bso_shifter_top dut (.CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    initial forever #2 clk = ~clk;
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic stop();
        mismatches++;
        results();
    endtask
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    always @(posedge clk)
    begin
        if (bvalid && bready)
            check({bresp, 32'h0}, q.pop_front());
        if (rvalid && rready)
            check({rresp, rdata}, q.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] e = RESP_OKAY);
        int n = 0;
        q.push_back({e, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= '1;
        wvalid <= '1;
        bready <= '1;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= '0;
            if (wready) wvalid <= '0;
            if (bvalid) bready <= '0;
            if (++n > 99) stop();
        end while (awvalid || wvalid || bready);
        // Let an edge pass so the next call never re-drives bready at once
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] e = RESP_OKAY);
        int n = 0;
        q.push_back({e, d});
        araddr <= a;
        arvalid <= '1;
        rready <= '1;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= '0;
            if (rvalid) rready <= '0;
            if (++n > 99) stop();
        end while (arvalid || rready);
        @(posedge clk);
    endtask
    task automatic exe(input logic [31:0] ins, f, s, a, st);
        wr(OFS_INSTR, ins);
        wr(OFS_FIRST, f);
        wr(OFS_SRC, s);
        wr(OFS_AMT, a);
        wr(OFS_STATUS, st);
        wr(OFS_CTRL, 32'h1);
    endtask
    task automatic chk(input logic [31:0] res, st);
        rd(OFS_RESULT, res);
        rd(OFS_STATUS, st);
    endtask
    // Reference shifter: carry in the top bit
    function automatic logic [32:0] sh(input logic [31:0] s,
            input logic [1:0] t, input logic [7:0] a, input logic r, c);
        logic [63:0] w;
        if (!r && t == 2'h3 && a == 8'h0)
            return {s[0], c, s[31:1]};
        if (!r && a == 8'h0 && t != 2'h0)
            a = 8'h20;
        if (a == 8'h0)
            return {c, s};
        case (t)
            2'h0: w = {32'h0, s} << a;
            2'h1: w = {s, 32'h0} >> a;
            2'h2: w = $signed({s, 32'h0}) >>> a;
            default: w = {s, s} >> a[4:0];
        endcase
        if (t == 2'h0)
            return {w[32], w[31:0]};
        return t == 2'h3 ? {w[31], w[31:0]} : {w[31], w[63:32]};
    endfunction
    initial
    begin
        logic [31:0] s, a, ins, res;
        logic [32:0] e;
        logic [3:0] fl;
        logic [4:0] k;
        void'($urandom(9));
        repeat (12) @(posedge clk);
        rst_n <= '1;
        repeat (3) @(posedge clk);
        rd(OFS_STATUS, STATUS_RST);
        rd(8'h2C, 32'h0, RESP_SLVERR);
        wr(OFS_INFO, 32'h5, RESP_SLVERR);
        wr(OFS_SAVED, 32'hF0000011);
        wr(OFS_IADDR, 32'h100);
        // Every type, both amount sources, multiples of 32 and zero
        for (int i = 0; i < 128; i++)
        begin
            s = $urandom;
            a = $urandom;
            fl = 4'($urandom);
            k = i[6] ? 5'($urandom) : 5'h0;
            a[7:0] = {i[5:3], k};
            ins = 32'h01B01000 | {20'h0, i[2] ? 5'h0 : k, i[1:0], i[2], 4'h0};
            e = sh(s, i[1:0], i[2] ? a[7:0] : {3'h0, k}, i[2], fl[1]);
            exe(ins, 32'h0, s, a, {fl, 28'h13});
            res = {e[31], e[31:0] == 0, e[32], fl[0], 28'h13};
            rd(OFS_RESULT, e[31:0]);
            rd(OFS_STATUS, res);
            rd(OFS_INFO, {15'h0, i[2], 16'h0111});
        end
        for (int j = 0; j < 16; j++)
        begin
            s = 32'($urandom % 256);
            res = 32'({s, s} >> (2 * j));
            exe(32'h03B01000 | {20'h0, 4'(j), s[7:0]}, 0, 0, 0, 32'h13);
            chk(res, {res[31], res == 0, j ? res[31] : 1'h0, 29'h13});
        end
        exe(32'h00901000, 32'h7FFFFFFF, 32'h1, 0, 32'h13);
        chk(32'h80000000, 32'h90000013);
        for (int op = 8; op < 12; op++)
        begin
            exe(32'h00101000 | op << 21, 0, 0, 0, 32'h13);
            chk(32'h80000000, {2'h1, op == 10, 29'h13});
            rd(OFS_INFO, 32'h101);
        end
        exe(32'h01A0F000, 0, 32'h1234, 0, 32'h13);
        rd(OFS_PCOUT, 32'h1234);
        rd(OFS_STATUS, 32'h13);
        rd(OFS_INFO, 32'h1213);
        exe(32'h01A0F010, 0, 32'h1234, 0, 32'h13);
        rd(OFS_INFO, 32'h11213);
        exe(32'h01B0F000, 0, 32'h40, 0, 32'h13);
        rd(OFS_STATUS, 32'hF0000011);
        exe(32'h01B0F000, 0, 32'h40, 0, 32'h10);
        rd(OFS_STATUS, 32'h10);
        exe(32'h0130F000, 0, 0, 0, 32'h13);
        rd(OFS_STATUS, 32'hF0000011);
        exe(32'h0130F000, 0, 0, 0, 32'h10);
        rd(OFS_STATUS, 32'h10);
        exe(32'h01B0100F, 0, 0, 0, 32'h13);
        chk(32'h108, 32'h13);
        exe(32'h01B0101F, 0, 0, 0, 32'h13);
        chk(32'h10C, 32'h13);
        exe(32'h01B01090, 0, 32'h5, 0, 32'h13);
        chk(32'h10C, 32'h13);
        exe(32'h01B01F10, 0, 32'h5, 0, 32'h13);
        chk(32'h10C, 32'h13);
        results();
    end
endmodule
